// ===== adc_trim_pkg.sv
package adc_trim_pkg;

  typedef logic [15:0] trim_word_t;
  typedef logic [11:0] offset_t;
  typedef logic [4:0]  gain_t;
  typedef logic [3:0]  slot_t;
  typedef logic [9:0]  reg_index_t;

  // Register indices; the byte address on the bus is four times the index.
  localparam reg_index_t IDX_OFFSET_TRIM_CONV5    = 10'h33E;
  localparam reg_index_t IDX_FINE_GAIN_CONV0      = 10'h360;
  localparam reg_index_t IDX_FINE_GAIN_CONV1      = 10'h361;
  localparam reg_index_t IDX_FINE_GAIN_CONV2_IN_A = 10'h362;
  localparam reg_index_t IDX_FINE_GAIN_CONV2_IN_B = 10'h363;
  localparam reg_index_t IDX_FINE_GAIN_CONV3_IN_C = 10'h364;
  localparam reg_index_t IDX_FINE_GAIN_CONV3_IN_D = 10'h365;
  localparam reg_index_t IDX_FINE_GAIN_CONV4      = 10'h366;
  localparam reg_index_t IDX_FINE_GAIN_CONV5      = 10'h367;
  localparam reg_index_t IDX_TRIM_STATUS          = 10'h370;
  localparam reg_index_t IDX_TRIM_CONTROL         = 10'h371;

  // Storage slots, also the fuse word address of each default.
  localparam slot_t SLOT_OFFSET_CONV5 = 4'h0;
  localparam slot_t SLOT_GAIN_CONV0   = 4'h1;
  localparam slot_t SLOT_GAIN_CONV1   = 4'h2;
  localparam slot_t SLOT_GAIN_CONV2_A = 4'h3;
  localparam slot_t SLOT_GAIN_CONV2_B = 4'h4;
  localparam slot_t SLOT_GAIN_CONV3_C = 4'h5;
  localparam slot_t SLOT_GAIN_CONV3_D = 4'h6;
  localparam slot_t SLOT_GAIN_CONV4   = 4'h7;
  localparam slot_t SLOT_GAIN_CONV5   = 4'h8;
  localparam slot_t SLOT_LAST         = 4'h8;
  localparam slot_t SLOT_NONE         = 4'hF;
  localparam int    NUM_SLOTS         = 9;

  // Field layout and reset values.
  localparam int         OFFSET_FIELD_MSB  = 11;
  localparam int         GAIN_FIELD_MSB    = 4;
  localparam trim_word_t OFFSET_REG_MASK   = 16'hFFFF;
  localparam trim_word_t GAIN_REG_MASK     = 16'h00FF;
  localparam trim_word_t TRIM_RESET_VALUE  = 16'h0000;
  localparam int         STATUS_DONE_BIT   = 0;
  localparam int         STATUS_BUSY_BIT   = 1;
  localparam int         CTRL_RELOAD_BIT   = 0;

  // Fuse array read access time and its cycle count at the system clock.
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int FUSE_ACCESS_NS    = 10;
  localparam int FUSE_READ_CYCLES  = (FUSE_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_ISSUE,
    LOAD_WAIT
  } load_state_t;

endpackage

// ===== adc_trim_register_bank.sv
// Overview of operation
// - Bits 11 to 0 of the converter-5 offset trim register drive the converter-5 offset output.
// - Converters 0 and 1 take their 5-bit fine gain from bits 4 to 0 of their own registers.
// - Converter 2 uses the input-A gain while sampling input A and the input-B gain otherwise.
// - Converter 3 uses the input-C gain while sampling input C and the input-D gain otherwise.
// - Converters 4 and 5 take their 5-bit fine gain from bits 4 to 0 of their own registers.
// - All trim defaults are loaded from the fuse array after reset and on a reload request.
//
// Our own choice: register access over Wishbone.
module adc_trim_register_bank
  import adc_trim_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     wbCyc,
  input  wire logic                     wbStb,
  input  wire logic                     wbWe,
  input  wire logic [11:0]              wbAdr,
  input  wire logic [3:0]               wbSel,
  input  wire logic [31:0]              wbDatIn,
  output logic [31:0]                   wbDatOut,
  output logic                          wbAck,
  input  wire logic                     sampleSelConv2,
  input  wire logic                     sampleSelConv3,
  input  wire adc_trim_pkg::trim_word_t fuseData,
  output logic                          fuseRd,
  output adc_trim_pkg::slot_t           fuseAddr,
  output adc_trim_pkg::offset_t         offsetConv5,
  output adc_trim_pkg::gain_t           gainConv0,
  output adc_trim_pkg::gain_t           gainConv1,
  output adc_trim_pkg::gain_t           gainConv2,
  output adc_trim_pkg::gain_t           gainConv3,
  output adc_trim_pkg::gain_t           gainConv4,
  output adc_trim_pkg::gain_t           gainConv5
);
  import adc_trim_pkg::*;

  trim_word_t trimReg [NUM_SLOTS];
  logic       loadStart;
  logic       loadDone;
  logic       loadValid;
  slot_t      loadSlot;
  trim_word_t loadData;
  logic       loadBusy;
  logic       accept;
  logic       reloadWrite;
  reg_index_t busIdx;
  slot_t      busSlot;
  logic [31:0] readWord;

  function automatic slot_t slotOf(input reg_index_t idx);
    case (idx)
      IDX_OFFSET_TRIM_CONV5:    slotOf = SLOT_OFFSET_CONV5;
      IDX_FINE_GAIN_CONV0:      slotOf = SLOT_GAIN_CONV0;
      IDX_FINE_GAIN_CONV1:      slotOf = SLOT_GAIN_CONV1;
      IDX_FINE_GAIN_CONV2_IN_A: slotOf = SLOT_GAIN_CONV2_A;
      IDX_FINE_GAIN_CONV2_IN_B: slotOf = SLOT_GAIN_CONV2_B;
      IDX_FINE_GAIN_CONV3_IN_C: slotOf = SLOT_GAIN_CONV3_C;
      IDX_FINE_GAIN_CONV3_IN_D: slotOf = SLOT_GAIN_CONV3_D;
      IDX_FINE_GAIN_CONV4:      slotOf = SLOT_GAIN_CONV4;
      IDX_FINE_GAIN_CONV5:      slotOf = SLOT_GAIN_CONV5;
      default:                  slotOf = SLOT_NONE;
    endcase
  endfunction

  function automatic trim_word_t slotMask(input slot_t slot);
    slotMask = (slot == SLOT_OFFSET_CONV5) ? OFFSET_REG_MASK : GAIN_REG_MASK;
  endfunction

  function automatic trim_word_t mergeBytes(input trim_word_t old, input logic [15:0] data,
                                            input logic [1:0] sel);
    mergeBytes = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
  endfunction

  assign busIdx      = wbAdr[11:2];
  assign busSlot     = slotOf(busIdx);
  // Bus requests wait while fuse defaults are being loaded so a load never races a write.
  assign accept      = wbCyc & wbStb & ~wbAck & loadDone;
  assign reloadWrite = accept & wbWe & (busIdx == IDX_TRIM_CONTROL) & wbSel[0]
                       & wbDatIn[CTRL_RELOAD_BIT];

  fuse_default_loader loader (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .loadStart (loadStart),
    .fuseData  (fuseData),
    .fuseRd    (fuseRd),
    .fuseAddr  (fuseAddr),
    .loadValid (loadValid),
    .loadSlot  (loadSlot),
    .loadData  (loadData),
    .loadBusy  (loadBusy)
  );

  // A load starts in the first cycle after reset and again on each reload write.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loadStart <= 1'b1;
    end else begin
      loadStart <= reloadWrite;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loadDone <= 1'b0;
    end else if (loadStart) begin
      loadDone <= 1'b0;
    end else if (loadValid && loadSlot == SLOT_LAST) begin
      loadDone <= 1'b1;
    end
  end

  // Gain registers clear bits 15 to 8; other reserved bits are kept as written.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        trimReg[i] <= TRIM_RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (loadValid && loadSlot == 4'(i)) begin
          trimReg[i] <= loadData & slotMask(4'(i));
        end else if (accept && wbWe && busSlot == 4'(i)) begin
          trimReg[i] <= mergeBytes(trimReg[i], wbDatIn[15:0], wbSel[1:0]) & slotMask(4'(i));
        end
      end
    end
  end

  always_comb begin
    readWord = 32'h0000_0000;
    if (busSlot != SLOT_NONE) begin
      readWord = {16'h0000, trimReg[busSlot]};
    end else if (busIdx == IDX_TRIM_STATUS) begin
      readWord[STATUS_DONE_BIT] = loadDone;
      readWord[STATUS_BUSY_BIT] = loadBusy;
    end
  end

  // Unmapped addresses are acknowledged, read as zero and ignore writes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= accept;
      if (accept && !wbWe) begin
        wbDatOut <= readWord;
      end
    end
  end

  // Trim outputs are registered; the input selects come from the same clock domain.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      offsetConv5 <= 12'h000;
      gainConv0   <= 5'h00;
      gainConv1   <= 5'h00;
      gainConv2   <= 5'h00;
      gainConv3   <= 5'h00;
      gainConv4   <= 5'h00;
      gainConv5   <= 5'h00;
    end else begin
      offsetConv5 <= trimReg[SLOT_OFFSET_CONV5][OFFSET_FIELD_MSB:0];
      gainConv0   <= trimReg[SLOT_GAIN_CONV0][GAIN_FIELD_MSB:0];
      gainConv1   <= trimReg[SLOT_GAIN_CONV1][GAIN_FIELD_MSB:0];
      gainConv2   <= sampleSelConv2 ? trimReg[SLOT_GAIN_CONV2_B][GAIN_FIELD_MSB:0]
                                    : trimReg[SLOT_GAIN_CONV2_A][GAIN_FIELD_MSB:0];
      gainConv3   <= sampleSelConv3 ? trimReg[SLOT_GAIN_CONV3_D][GAIN_FIELD_MSB:0]
                                    : trimReg[SLOT_GAIN_CONV3_C][GAIN_FIELD_MSB:0];
      gainConv4   <= trimReg[SLOT_GAIN_CONV4][GAIN_FIELD_MSB:0];
      gainConv5   <= trimReg[SLOT_GAIN_CONV5][GAIN_FIELD_MSB:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence fullWriteTo(reg_index_t idx);
    wbCyc && wbStb && wbWe && wbAck && busIdx == idx && wbSel[1:0] == 2'b11;
  endsequence

  sequence outputSettles;
    ##2 1'b1;
  endsequence

  sequence lowByteWriteTo(reg_index_t idx);
    wbCyc && wbStb && wbWe && wbAck && busIdx == idx && wbSel[1:0] == 2'b01;
  endsequence

  sequence readTaken(reg_index_t idx);
    wbCyc && wbStb && !wbWe && wbAck && busIdx == idx;
  endsequence

  offset_write_apply_a: assert property (
    fullWriteTo(IDX_OFFSET_TRIM_CONV5) |-> trimReg[SLOT_OFFSET_CONV5] == wbDatIn[15:0])
    else $error("offset register does not hold the written word");

  offset_value_follow_a: assert property (
    fullWriteTo(IDX_OFFSET_TRIM_CONV5) ##1 !loadValid
      |-> ##1 offsetConv5 == $past(wbDatIn[11:0], 2))
    else $error("converter 5 offset does not follow the written value");

  gain_conv0_follow_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV0) ##1 !loadValid
      |-> ##1 gainConv0 == $past(wbDatIn[4:0], 2))
    else $error("converter 0 gain does not follow the written value");

  gain_conv1_track_a: assert property (
    ##1 gainConv1 == $past(trimReg[SLOT_GAIN_CONV1][4:0]))
    else $error("converter 1 gain differs from its register");

  conv2_input_select_a: assert property (
    ##1 gainConv2 == ($past(sampleSelConv2) ? $past(trimReg[SLOT_GAIN_CONV2_B][4:0])
                                             : $past(trimReg[SLOT_GAIN_CONV2_A][4:0])))
    else $error("converter 2 gain picked from the wrong input register");

  conv3_input_select_a: assert property (
    $rose(sampleSelConv3) && $stable(trimReg[SLOT_GAIN_CONV3_D])
      |=> gainConv3 == $past(trimReg[SLOT_GAIN_CONV3_D][4:0]))
    else $error("converter 3 gain not switched to input D");

  gain_conv45_follow_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV5) ##1 !loadValid
      |-> ##1 gainConv5 == $past(wbDatIn[4:0], 2) && $stable(gainConv4))
    else $error("converter 5 gain does not follow its own register");

  fuse_word_load_a: assert property (
    loadValid |=> trimReg[$past(loadSlot)] == ($past(loadData) & slotMask($past(loadSlot))))
    else $error("fuse word not stored in its slot");

  fuse_load_done_a: assert property (
    loadStart |=> !loadDone ##[1:60] loadDone)
    else $error("fuse default load did not finish in time");

  bus_stall_load_a: assert property (
    !loadDone |=> !wbAck)
    else $error("bus answered while defaults were loading");

  offset_low_lane_a: assert property (
    lowByteWriteTo(IDX_OFFSET_TRIM_CONV5) |-> trimReg[SLOT_OFFSET_CONV5]
      == {$past(trimReg[SLOT_OFFSET_CONV5][15:8]), wbDatIn[7:0]})
    else $error("offset low byte write touched the upper byte");

  offset_hold_a: assert property (
    $stable(trimReg[SLOT_OFFSET_CONV5]) |=> $stable(offsetConv5))
    else $error("converter 5 offset moved without a register change");

  offset_read_back_a: assert property (
    readTaken(IDX_OFFSET_TRIM_CONV5) |-> wbDatOut == {16'h0000, trimReg[SLOT_OFFSET_CONV5]})
    else $error("offset register read returned the wrong word");

  gain_conv1_follow_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV1) ##1 !loadValid
      |-> ##1 gainConv1 == $past(wbDatIn[4:0], 2))
    else $error("converter 1 gain does not follow the written value");

  gain_upper_zero_a: assert property (
    trimReg[SLOT_GAIN_CONV0][15:8] == 8'h00 && trimReg[SLOT_GAIN_CONV1][15:8] == 8'h00)
    else $error("gain register holds bits above its byte");

  gain_read_back_a: assert property (
    readTaken(IDX_FINE_GAIN_CONV0) |-> wbDatOut == {16'h0000, trimReg[SLOT_GAIN_CONV0]})
    else $error("converter 0 gain read returned the wrong word");

  conv0_hold_a: assert property (
    $stable(trimReg[SLOT_GAIN_CONV0]) |=> $stable(gainConv0))
    else $error("converter 0 gain moved without a register change");

  conv2_b_isolated_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV2_IN_B) ##0 $stable(sampleSelConv2) && !sampleSelConv2
      |=> $stable(gainConv2))
    else $error("converter 2 gain followed input B while sampling input A");

  conv2_sel_switch_a: assert property (
    $rose(sampleSelConv2) |=> gainConv2 == $past(trimReg[SLOT_GAIN_CONV2_B][4:0]))
    else $error("converter 2 gain not switched to input B");

  conv3_sel_back_a: assert property (
    $fell(sampleSelConv3) |=> gainConv3 == $past(trimReg[SLOT_GAIN_CONV3_C][4:0]))
    else $error("converter 3 gain not switched back to input C");

  conv3_d_isolated_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV3_IN_D) ##0 $stable(sampleSelConv3) && !sampleSelConv3
      |=> $stable(gainConv3))
    else $error("converter 3 gain followed input D while sampling input C");

  gain_conv4_follow_a: assert property (
    fullWriteTo(IDX_FINE_GAIN_CONV4)
      |-> outputSettles ##0 gainConv4 == $past(wbDatIn[4:0], 2))
    else $error("converter 4 gain does not follow the written value");

  conv5_read_back_a: assert property (
    readTaken(IDX_FINE_GAIN_CONV5) |-> wbDatOut == {16'h0000, trimReg[SLOT_GAIN_CONV5]})
    else $error("converter 5 gain read returned the wrong word");

  conv5_hold_a: assert property (
    $stable(trimReg[SLOT_GAIN_CONV5]) |=> $stable(gainConv5))
    else $error("converter 5 gain moved without a register change");

  fuse_read_order_a: assert property (
    fuseRd && fuseAddr != SLOT_LAST |-> ##3 fuseRd && fuseAddr == $past(fuseAddr, 3) + 4'h1)
    else $error("fuse words not read in slot order");

  fuse_single_flight_a: assert property (
    fuseRd |=> (!fuseRd) [*2])
    else $error("second fuse read issued while one is in flight");

  fuse_sample_point_a: assert property (
    fuseRd |-> ##2 loadValid && loadSlot == $past(fuseAddr, 2)
      && loadData == $past(fuseData))
    else $error("fuse word not taken at its access time");

  status_read_a: assert property (
    readTaken(IDX_TRIM_STATUS)
      |-> wbDatOut == {30'h0000_0000, $past(loadBusy), $past(loadDone)})
    else $error("status read does not show the load state");

  reload_restart_a: assert property (
    fullWriteTo(IDX_TRIM_CONTROL) ##0 wbDatIn[CTRL_RELOAD_BIT] |-> loadStart ##1 !loadDone)
    else $error("reload request did not restart the fuse load");

endmodule

// ===== adc_trim_register_bank_tb_top.sv
module adc_trim_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_trim_pkg::*;

  logic        clk_sys, rst, wbCyc, wbStb, wbWe, wbAck, fuseRd;
  logic        sampleSelConv2, sampleSelConv3;
  logic [11:0] wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatIn, wbDatOut;
  trim_word_t  fuseData;
  slot_t       fuseAddr, rdAddr;
  offset_t     offsetConv5;
  gain_t       gainConv0, gainConv1, gainConv2, gainConv3, gainConv4, gainConv5;
  int          num_errors = 0;
  int          checks = 0;
  int          hold = 0;
  logic [31:0] rnd = 32'd66271;
  logic [32:0] e;
  logic [32:0] expq [$];
  trim_word_t  fuse [NUM_SLOTS];
  trim_word_t  mdl [NUM_SLOTS];
  trim_word_t  v;
  reg_index_t  idx [NUM_SLOTS] = '{IDX_OFFSET_TRIM_CONV5, IDX_FINE_GAIN_CONV0,
    IDX_FINE_GAIN_CONV1, IDX_FINE_GAIN_CONV2_IN_A, IDX_FINE_GAIN_CONV2_IN_B,
    IDX_FINE_GAIN_CONV3_IN_C, IDX_FINE_GAIN_CONV3_IN_D, IDX_FINE_GAIN_CONV4,
    IDX_FINE_GAIN_CONV5};

  adc_trim_register_bank dut (.clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .sampleSelConv2(sampleSelConv2), .sampleSelConv3(sampleSelConv3),
    .fuseData(fuseData), .fuseRd(fuseRd), .fuseAddr(fuseAddr), .offsetConv5(offsetConv5),
    .gainConv0(gainConv0), .gainConv1(gainConv1), .gainConv2(gainConv2),
    .gainConv3(gainConv3), .gainConv4(gainConv4), .gainConv5(gainConv5));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction

  // Fuse array: the word stays valid a little past the access time, then the
  // lines toggle so that a late sample cannot pass by luck.
  always @(posedge clk_sys) begin
    if (fuseRd === 1'b1) begin
      rdAddr <= fuseAddr;
      hold <= FUSE_READ_CYCLES + 2;
      fuseData <= fuse[fuseAddr];
    end else if (hold > 0) begin
      hold <= hold - 1;
      fuseData <= fuse[rdAddr];
    end else begin
      fuseData <= ~fuseData;
    end
  end

  always @(posedge clk_sys) begin
    if (wbAck === 1'b1) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: ack with no request", $time);
      end else begin
        e = expq.pop_front();
        if (e[32]) begin
          checks++;
          if (wbDatOut !== e[31:0]) begin
            num_errors++;
            $display("wrong value at %0t: read %h expected %h", $time, wbDatOut, e[31:0]);
          end
        end
      end
    end
  end

  task automatic close_out();
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus(input logic we, input reg_index_t a, input trim_word_t d,
                     input logic [3:0] s, input logic [32:0] x);
    int n;
    expq.push_back(x);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {a, 2'b00};
    wbSel <= s;
    wbDatIn <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 500);
    if (n >= 500) begin
      num_errors++;
      $display("wrong value at %0t: no acknowledge", $time);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input int k, input trim_word_t d, input logic [3:0] s);
    bus(1'b1, idx[k], d, s, 33'h000000000);
    if (s[0]) mdl[k][7:0] = d[7:0];
    if (s[1] && k == 0) mdl[k][15:8] = d[15:8];
  endtask

  task automatic rdall();
    for (int k = 0; k < NUM_SLOTS; k++) bus(1'b0, idx[k], 16'h0000, 4'hF, {17'h10000, mdl[k]});
  endtask

  task automatic ld();
    for (int k = 0; k < NUM_SLOTS; k++) mdl[k] = fuse[k] & (k == 0 ? 16'hFFFF : 16'h00FF);
  endtask

  task automatic cmp(input logic [11:0] g, input logic [11:0] x);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: trim %h expected %h", $time, g, x);
    end
  endtask

  task automatic outs();
    repeat (3) @(posedge clk_sys);
    cmp(offsetConv5, mdl[0][11:0]);
    cmp(12'(gainConv0), 12'(mdl[1][4:0]));
    cmp(12'(gainConv1), 12'(mdl[2][4:0]));
    cmp(12'(gainConv2), 12'(sampleSelConv2 ? mdl[4][4:0] : mdl[3][4:0]));
    cmp(12'(gainConv3), 12'(sampleSelConv3 ? mdl[6][4:0] : mdl[5][4:0]));
    cmp(12'(gainConv4), 12'(mdl[7][4:0]));
    cmp(12'(gainConv5), 12'(mdl[8][4:0]));
  endtask

  task automatic newfuse();
    for (int k = 0; k < NUM_SLOTS; k++) begin
      rnd = step(rnd);
      fuse[k] = rnd[15:0];
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, sampleSelConv2, sampleSelConv3} = 5'h00;
    wbAdr = 12'h000;
    wbSel = 4'h0;
    wbDatIn = 32'h00000000;
    fuseData = 16'h0000;
    newfuse();
    ld();
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdall();
    bus(1'b0, IDX_TRIM_STATUS, 16'h0000, 4'hF, 33'h100000001);
    for (int m = 0; m < 4; m++) begin
      sampleSelConv2 <= m[0];
      sampleSelConv3 <= m[1];
      outs();
    end
    // Reserved bits are kept zero on every write, as software must.
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
        rnd = step(rnd);
        v = rnd[15:0] & (k == 0 ? 16'h0FFF : 16'h001F);
        wr(k, v, 4'h3);
      end
      rdall();
      sampleSelConv2 <= rnd[20];
      sampleSelConv3 <= rnd[21];
      outs();
    end
    wr(0, 16'h0ABC, 4'h1);
    wr(3, 16'h0015, 4'h2);
    rdall();
    bus(1'b1, 10'h300, 16'h0055, 4'h3, 33'h000000000);
    bus(1'b0, 10'h300, 16'h0000, 4'hF, 33'h100000000);
    outs();
    newfuse();
    bus(1'b1, IDX_TRIM_CONTROL, 16'h0001, 4'h3, 33'h000000000);
    ld();
    rdall();
    outs();
    // A second reset clears the trims, then the fuse load must run again.
    newfuse();
    @(posedge clk_sys);
    rst <= 1'b1;
    for (int k = 0; k < NUM_SLOTS; k++) mdl[k] = 16'h0000;
    outs();
    rst <= 1'b0;
    ld();
    rdall();
    outs();
    close_out();
  end
endmodule

// ===== fuse_default_loader.sv
module fuse_default_loader
  import adc_trim_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     loadStart,
  input  wire adc_trim_pkg::trim_word_t fuseData,
  output logic                          fuseRd,
  output adc_trim_pkg::slot_t           fuseAddr,
  output logic                          loadValid,
  output adc_trim_pkg::slot_t           loadSlot,
  output adc_trim_pkg::trim_word_t      loadData,
  output logic                          loadBusy
);
  import adc_trim_pkg::*;

  load_state_t state;
  logic [3:0]  waitCount;

  // The fuse array is slow, so each word is read once and held by the bank.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= LOAD_IDLE;
      waitCount <= 4'h0;
      fuseRd    <= 1'b0;
      fuseAddr  <= 4'h0;
      loadValid <= 1'b0;
      loadSlot  <= 4'h0;
      loadData  <= TRIM_RESET_VALUE;
      loadBusy  <= 1'b0;
    end else begin
      fuseRd    <= 1'b0;
      loadValid <= 1'b0;
      case (state)
        LOAD_IDLE: begin
          if (loadStart) begin
            fuseAddr <= SLOT_OFFSET_CONV5;
            loadBusy <= 1'b1;
            state    <= LOAD_ISSUE;
          end
        end
        LOAD_ISSUE: begin
          fuseRd    <= 1'b1;
          waitCount <= 4'(FUSE_READ_CYCLES);
          state     <= LOAD_WAIT;
        end
        LOAD_WAIT: begin
          if (waitCount == 4'h1) begin
            loadValid <= 1'b1;
            loadSlot  <= fuseAddr;
            loadData  <= fuseData;
            if (fuseAddr == SLOT_LAST) begin
              loadBusy <= 1'b0;
              state    <= LOAD_IDLE;
            end else begin
              fuseAddr <= fuseAddr + 4'h1;
              state    <= LOAD_ISSUE;
            end
          end else begin
            waitCount <= waitCount - 4'h1;
          end
        end
        default: begin
          state <= LOAD_IDLE;
        end
      endcase
    end
  end

endmodule
